//--- hw/pmc_pkg.sv
// Package for the power mode controller: mode codes, boot codes, timing counts.
// Assumes a single 40 MHz system clock.
package pmc_pkg;
  // ---------------------------------------------------------------
  // Low-power mode selection
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_SLEEP      = 3'h0;
  localparam logic [2:0] MODE_DEEP       = 3'h1;
  localparam logic [2:0] MODE_DEEP_1     = 3'h2;
  localparam logic [2:0] MODE_DEEP_2     = 3'h3;
  localparam logic [2:0] MODE_STANDBY    = 3'h4;
  // ---------------------------------------------------------------
  // Boot source codes
  // ---------------------------------------------------------------
  localparam logic [1:0] BOOT_MAIN_FLASH = 2'h0;
  localparam logic [1:0] BOOT_SYSTEM_MEM = 2'h1;
  localparam logic [1:0] BOOT_SRAM       = 2'h2;
  // ---------------------------------------------------------------
  // System clock source codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CLKSRC_RC8M     = 2'h0;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int         EXT_LINES       = 16;
  localparam int         CLK_MHZ         = 40;
  localparam int         DOMAIN_UP_NS    = 10000;
  localparam int         DOMAIN_UP_CYC   = (DOMAIN_UP_NS * CLK_MHZ + 999) / 1000;
  localparam int         CNT_W           = 16;
endpackage

//--- hw/pmc_power_mode_controller.sv
// Power mode controller: sequences sleep, deep-sleep variants and standby,
// picks the boot source and holds the system in reset on low supply.
// Assumes all inputs synchronous to sys_clk_i; this logic sits in the always-on domain.
//
// Overview of operation
// - Sleep stops only the core clock; any interrupt or event wakes.
// - Deep-sleep gates core-domain clocks and disables both RCs, crystal and PLLs.
// - Plain deep-sleep keeps SRAM and all registers powered.
// - Deep-sleep variants wake on any event-controller source.
// - Leaving deep-sleep selects the internal 8 MHz RC as system clock.
// - Deep-sleep 1 removes power from switchable core domain B.
// - Waking deep-sleep 1 waits extra for domain B to re-power.
// - Deep-sleep 2 removes domains A and B; only first 32K SRAM kept.
// - Waking deep-sleep 2 waits extra for domains A and B.
// - Standby powers off core domain, regulator, RCs, crystal and PLL.
// - Standby leaves only on reset pin, RTC alarm, watchdog or wake pin rise.
// - Boot pins sampled at startup pick flash, system memory or SRAM.
// - Reset held while supply detectors report low; detectors always active.
// - Low-voltage detector output raises a warning interrupt.
// - System reset returns core and peripherals to reset state.
`timescale 1ns/1ps
module pmc_power_mode_controller #(
  parameter int DOMAIN_UP_CYCLES = pmc_pkg::DOMAIN_UP_CYC
) (
  // Clock, reset, enable
  input  wire logic                         sys_clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         clk_en_i,
  // Processor request
  input  wire logic                         wfi_req_i,
  input  wire logic [2:0]                   mode_sel_i,
  input  wire logic                         irq_pending_i,
  // Wake sources
  input  wire logic [pmc_pkg::EXT_LINES-1:0] ext_line_i,
  input  wire logic                         rtc_alarm_i,
  input  wire logic                         usb_wake_i,
  input  wire logic                         two_wire_port_2_wake_i,
  input  wire logic                         serial_port_5_wake_i,
  input  wire logic                         external_reset_pin_n_i,
  input  wire logic                         free_watchdog_reset_i,
  input  wire logic                         wakeup_pin_i,
  // Supply supervisors and boot pins
  input  wire logic                         por_low_i,
  input  wire logic                         power_down_reset_detector_low_i,
  input  wire logic                         low_voltage_detector_i,
  input  wire logic [1:0]                   boot_pins_i,
  // Clock and power controls
  output logic                              core_clk_en_o,
  output logic                              core_domain_clk_en_o,
  output logic                              internal_8mhz_rc_en_o,
  output logic                              internal_48mhz_rc_en_o,
  output logic                              external_high_speed_crystal_en_o,
  output logic                              pll_en_o,
  output logic                              switchable_core_domain_a_pwr_o,
  output logic                              switchable_core_domain_b_pwr_o,
  output logic                              core_regulator_en_o,
  output logic                              sram_upper_retain_o,
  output logic                              force_clk_rc8m_o,
  // Status
  output logic                              sys_reset_n_o,
  output logic                              lvd_irq_o,
  output logic [1:0]                        boot_sel_o,
  output logic                              boot_valid_o,
  output logic                              wake_o
);
  import pmc_pkg::*;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_DEEP, ST_DEEP_1, ST_DEEP_2, ST_STANDBY, ST_POWER_UP} pmc_state_e;

  pmc_state_e       state;
  pmc_state_e       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             wake_pin_d;
  logic             next_wake_pin_d;
  logic             stby_reset;
  logic             next_stby_reset;
  logic             boot_done;
  logic             next_boot_done;
  logic [1:0]       boot_sel;
  logic [1:0]       next_boot_sel;
  logic             lvd_irq;
  logic             next_lvd_irq;
  logic             wake;
  logic             next_wake;
  logic             supply_low;
  logic             event_wake;
  logic             stby_wake;

  // Supply detectors are never gated by mode or clock enable
  assign supply_low = por_low_i | power_down_reset_detector_low_i;
  assign event_wake = (|ext_line_i) | rtc_alarm_i | low_voltage_detector_i | usb_wake_i
                    | two_wire_port_2_wake_i | serial_port_5_wake_i | irq_pending_i;
  assign stby_wake  = ~external_reset_pin_n_i | rtc_alarm_i | free_watchdog_reset_i
                    | (wakeup_pin_i & ~wake_pin_d);

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_wake_pin_d = wakeup_pin_i;
    next_stby_reset = 1'b0;
    next_boot_done  = 1'b1;
    next_boot_sel   = boot_sel;
    next_lvd_irq    = low_voltage_detector_i;
    next_wake       = 1'b0;
    if (!boot_done) begin
      // Pin 0 low boots flash; otherwise pin 1 picks system memory or SRAM
      next_boot_sel = !boot_pins_i[0] ? BOOT_MAIN_FLASH :
                      (boot_pins_i[1] ? BOOT_SRAM : BOOT_SYSTEM_MEM);
    end
    case (state)
      ST_RUN: begin
        if (wfi_req_i) begin
          case (mode_sel_i)
            MODE_SLEEP:   next_state = ST_SLEEP;
            MODE_DEEP:    next_state = ST_DEEP;
            MODE_DEEP_1:  next_state = ST_DEEP_1;
            MODE_DEEP_2:  next_state = ST_DEEP_2;
            MODE_STANDBY: next_state = ST_STANDBY;
            default:      next_state = ST_RUN;
          endcase
        end
      end
      ST_SLEEP: begin
        if (event_wake) begin
          next_state = ST_RUN;
          next_wake  = 1'b1;
        end
      end
      ST_DEEP: begin
        if (event_wake) begin
          next_state = ST_RUN;
          next_wake  = 1'b1;
        end
      end
      ST_DEEP_1, ST_DEEP_2: begin
        if (event_wake) begin
          // Domain re-power delay before the core resumes
          next_state = ST_POWER_UP;
          next_cnt   = CNT_W'(DOMAIN_UP_CYCLES - 1);
        end
      end
      ST_STANDBY: begin
        if (stby_wake) begin
          // Core domain contents are gone, so exit is through a system reset
          next_stby_reset = 1'b1;
          next_state      = ST_RUN;
          next_boot_done  = 1'b0;
        end
      end
      ST_POWER_UP: begin
        if (cnt == '0) begin
          next_state = ST_RUN;
          next_wake  = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state      <= ST_RUN;
      cnt        <= '0;
      wake_pin_d <= 1'b0;
      stby_reset <= 1'b0;
      boot_done  <= 1'b0;
      boot_sel   <= BOOT_MAIN_FLASH;
      lvd_irq    <= 1'b0;
      wake       <= 1'b0;
    end else if (supply_low) begin
      // Low supply forces everything back to its reset state
      state      <= ST_RUN;
      cnt        <= '0;
      wake_pin_d <= 1'b0;
      stby_reset <= 1'b0;
      boot_done  <= 1'b0;
      boot_sel   <= BOOT_MAIN_FLASH;
      lvd_irq    <= 1'b0;
      wake       <= 1'b0;
    end else if (clk_en_i) begin
      state      <= next_state;
      cnt        <= next_cnt;
      wake_pin_d <= next_wake_pin_d;
      stby_reset <= next_stby_reset;
      boot_done  <= next_boot_done;
      boot_sel   <= next_boot_sel;
      lvd_irq    <= next_lvd_irq;
      wake       <= next_wake;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic deep_any;
  assign deep_any = (state == ST_DEEP) | (state == ST_DEEP_1) | (state == ST_DEEP_2) | (state == ST_STANDBY);

  assign core_clk_en_o                    = (state == ST_RUN);
  assign core_domain_clk_en_o             = ~deep_any & (state != ST_POWER_UP);
  assign internal_8mhz_rc_en_o            = ~deep_any;
  assign internal_48mhz_rc_en_o           = ~deep_any;
  assign external_high_speed_crystal_en_o = ~deep_any & ~force_clk_rc8m_o;
  assign pll_en_o                         = ~deep_any & ~force_clk_rc8m_o;
  // Plain deep-sleep keeps both domains and all SRAM powered
  assign switchable_core_domain_a_pwr_o   = (state != ST_DEEP_2) & (state != ST_STANDBY);
  assign switchable_core_domain_b_pwr_o   = (state != ST_DEEP_1) & (state != ST_DEEP_2)
                                          & (state != ST_STANDBY);
  assign sram_upper_retain_o              = (state != ST_DEEP_2) & (state != ST_STANDBY);
  assign core_regulator_en_o              = (state != ST_STANDBY);

  // Sticky RC8M selection after a deep exit; cleared only by reset_n_i or low supply
  logic rc8m_hold;
  logic next_rc8m_hold;
  always_comb begin
    next_rc8m_hold = rc8m_hold;
    if (deep_any) begin
      next_rc8m_hold = 1'b1;
    end else if (wfi_req_i || !core_clk_en_o) begin
      next_rc8m_hold = rc8m_hold;
    end
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rc8m_hold <= 1'b0;
    end else if (supply_low) begin
      rc8m_hold <= 1'b0;
    end else if (clk_en_i) begin
      rc8m_hold <= next_rc8m_hold;
    end
  end
  assign force_clk_rc8m_o = rc8m_hold;

  assign sys_reset_n_o = reset_n_i & ~supply_low & ~stby_reset & boot_done;
  assign lvd_irq_o     = lvd_irq;
  assign boot_sel_o    = boot_sel;
  assign boot_valid_o  = boot_done;
  assign wake_o        = wake;
endmodule

//--- bench/pmc_cpu_model.sv
// CPU side model: sets the low-power mode, then issues a one-cycle wait request.
// Assumes the bench raises go_i for one cycle while the controller runs.
`timescale 1ns/1ps
module pmc_cpu_model (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       go_i,
  input  wire logic [2:0] mode_i,
  output logic            wfi_req_o,
  output logic [2:0]      mode_sel_o
);
  logic armed;
  // Mode is set a cycle ahead so the request never races it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed      <= 1'b0;
      wfi_req_o  <= 1'b0;
      mode_sel_o <= 3'h0;
    end else begin
      armed     <= go_i;
      wfi_req_o <= armed;
      if (go_i) begin
        mode_sel_o <= mode_i;
      end
    end
  end
endmodule

//--- bench/pmc_checker_properties.sv
// Checker: relations between the controller's supply, wake and power outputs.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/1ps
module pmc_checker #(
  parameter int DOMAIN_UP_CYCLES = pmc_pkg::DOMAIN_UP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic irq_pending_i,
  input wire logic por_low_i,
  input wire logic power_down_reset_detector_low_i,
  input wire logic low_voltage_detector_i,
  input wire logic core_clk_en_o,
  input wire logic core_domain_clk_en_o,
  input wire logic internal_8mhz_rc_en_o,
  input wire logic pll_en_o,
  input wire logic switchable_core_domain_a_pwr_o,
  input wire logic switchable_core_domain_b_pwr_o,
  input wire logic core_regulator_en_o,
  input wire logic force_clk_rc8m_o,
  input wire logic sys_reset_n_o,
  input wire logic lvd_irq_o,
  input wire logic wake_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Power-up phase: core domain clocks off while the 8 MHz RC already runs
  // A counter rather than a delay, so the long default count stays cheap to check
  logic pu;
  int   up_cnt;
  assign pu = !core_domain_clk_en_o && internal_8mhz_rc_en_o;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_cnt <= 0;
    end else begin
      up_cnt <= pu ? up_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_supply_hold: assert property ((por_low_i || power_down_reset_detector_low_i) |-> !sys_reset_n_o)
    else $error("reset not held on low supply");
  a_deep_gate: assert property (!internal_8mhz_rc_en_o |->
    !core_domain_clk_en_o && !pll_en_o && !core_clk_en_o) else $error("clocks left running");
  a_domain_pair: assert property (!switchable_core_domain_a_pwr_o |-> !switchable_core_domain_b_pwr_o)
    else $error("domain a off alone");
  a_domain_b_off: assert property (!switchable_core_domain_b_pwr_o |->
    !core_clk_en_o && !internal_8mhz_rc_en_o) else $error("domain b off while running");
  a_regulator_off: assert property (!core_regulator_en_o |-> !switchable_core_domain_a_pwr_o && !pll_en_o)
    else $error("regulator off with domain up");
  a_rc8m_force: assert property ($fell(internal_8mhz_rc_en_o) |-> ##[0:1] force_clk_rc8m_o)
    else $error("clock override missing");
  a_lvd_warn: assert property ($rose(low_voltage_detector_i) |=> lvd_irq_o)
    else $error("no low voltage warning");
  a_wake_pulse: assert property (wake_o |-> core_clk_en_o ##1 !wake_o)
    else $error("wake pulse wrong");
  a_sleep_wake: assert property (irq_pending_i && !core_clk_en_o && core_domain_clk_en_o |->
    ##[1:4] core_clk_en_o) else $error("sleep not left");
  a_domain_delay: assert property ($fell(pu) && sys_reset_n_o |->
    core_clk_en_o && up_cnt == DOMAIN_UP_CYCLES) else $error("power-up delay wrong");
endmodule
bind pmc_power_mode_controller pmc_checker #(.DOMAIN_UP_CYCLES(DOMAIN_UP_CYCLES)) u_chk (
  .sys_clk_i                       (sys_clk_i),
  .reset_n_i                       (reset_n_i),
  .irq_pending_i                   (irq_pending_i),
  .por_low_i                       (por_low_i),
  .power_down_reset_detector_low_i (power_down_reset_detector_low_i),
  .low_voltage_detector_i          (low_voltage_detector_i),
  .core_clk_en_o                   (core_clk_en_o),
  .core_domain_clk_en_o            (core_domain_clk_en_o),
  .internal_8mhz_rc_en_o           (internal_8mhz_rc_en_o),
  .pll_en_o                        (pll_en_o),
  .switchable_core_domain_a_pwr_o  (switchable_core_domain_a_pwr_o),
  .switchable_core_domain_b_pwr_o  (switchable_core_domain_b_pwr_o),
  .core_regulator_en_o             (core_regulator_en_o),
  .force_clk_rc8m_o                (force_clk_rc8m_o),
  .sys_reset_n_o                   (sys_reset_n_o),
  .lvd_irq_o                       (lvd_irq_o),
  .wake_o                          (wake_o)
);

//--- bench/test_power_mode_controller.sv
// Bench for the power mode controller: mode table, standby exits, supply and boot.
// Assumes a two-cycle domain power-up count and a one-cycle wait request.
`timescale 1ns/1ps
module test_power_mode_controller;
  import pmc_pkg::*;
  // ---------------------------------------------------------------
  // Signals and table
  // ---------------------------------------------------------------
  typedef struct {logic [2:0] m; int s; logic [9:0] lp;} pmc_row_s;
  logic sys_clk_i = 0, reset_n_i = 0, clk_en_i = 1, irq_pending_i = 0, rtc_alarm_i = 0, usb_wake_i = 0;
  logic two_wire_port_2_wake_i = 0, serial_port_5_wake_i = 0, external_reset_pin_n_i = 1, free_watchdog_reset_i = 0;
  logic wakeup_pin_i = 0, por_low_i = 0, power_down_reset_detector_low_i = 0, low_voltage_detector_i = 0, go = 0;
  logic wfi_req_i, core_clk_en_o, core_domain_clk_en_o, internal_8mhz_rc_en_o, internal_48mhz_rc_en_o, pll_en_o;
  logic external_high_speed_crystal_en_o, switchable_core_domain_a_pwr_o, switchable_core_domain_b_pwr_o;
  logic core_regulator_en_o, sram_upper_retain_o, force_clk_rc8m_o, sys_reset_n_o, lvd_irq_o, boot_valid_o, wake_o;
  logic [2:0] mode = 3'h0, mode_sel_i;
  logic [15:0] ext_line_i = 16'h0;
  logic [1:0] boot_pins_i = 2'h0, boot_sel_o;
  logic [1:0] bp[3] = '{2'h3, 2'h1, 2'h0};
  logic [1:0] bs[3] = '{BOOT_SRAM, BOOT_SYSTEM_MEM, BOOT_MAIN_FLASH};
  int err_count = 0, check_count = 0;
  int wake_count = 0;
  pmc_row_s rows[11] = '{'{MODE_SLEEP, 0, 10'h1ff}, '{MODE_DEEP, 1, 10'h00f}, '{MODE_DEEP, 2, 10'h00f},
    '{MODE_DEEP_1, 3, 10'h00b}, '{MODE_DEEP_1, 4, 10'h00b}, '{MODE_DEEP_2, 5, 10'h002}, '{MODE_DEEP_2, 6, 10'h002},
    '{MODE_STANDBY, 7, 10'h000}, '{MODE_STANDBY, 2, 10'h000}, '{MODE_STANDBY, 8, 10'h000},
    '{MODE_STANDBY, 9, 10'h000}};
  pmc_power_mode_controller #(.DOMAIN_UP_CYCLES(2)) uut (.*);
  pmc_cpu_model cpu (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .go_i(go), .mode_i(mode),
    .wfi_req_o(wfi_req_i), .mode_sel_o(mode_sel_i));
  always #12.5 sys_clk_i = ~sys_clk_i;
  // Wake pulses last one cycle, so count them mid-cycle where they are settled
  always @(negedge sys_clk_i) begin
    if (wake_o === 1'b1) begin
      wake_count++;
    end
  end
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic drive(input int s, input logic v);
    case (s)
      0: irq_pending_i <= v;
      1: ext_line_i[15] <= v;
      2: rtc_alarm_i <= v;
      3: usb_wake_i <= v;
      4: two_wire_port_2_wake_i <= v;
      5: serial_port_5_wake_i <= v;
      6: low_voltage_detector_i <= v;
      7: wakeup_pin_i <= v;
      8: free_watchdog_reset_i <= v;
      9: external_reset_pin_n_i <= !v;
      10: por_low_i <= v;
      default: power_down_reset_detector_low_i <= v;
    endcase
  endtask
  task automatic pulse(input int s);
    @(posedge sys_clk_i);
    drive(s, 1'b1);
    @(posedge sys_clk_i);
    drive(s, 1'b0);
  endtask
  task automatic enter(input logic [2:0] m);
    @(posedge sys_clk_i);
    go <= 1'b1;
    mode <= m;
    @(posedge sys_clk_i);
    go <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
  // Bounded so a controller stuck asleep cannot hang the run
  task automatic wait_run;
    int n;
    n = 0;
    while (!(core_clk_en_o === 1'b1 && sys_reset_n_o === 1'b1) && n < 30) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(n < 30, "no return to run");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    conclude;
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    chk(sys_reset_n_o === 1'b0, "reset not held");
    reset_n_i <= 1'b1;
    wait_run;
    chk(boot_sel_o === BOOT_MAIN_FLASH && force_clk_rc8m_o === 1'b0, "reset state");
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    enter(MODE_SLEEP);
    chk(core_clk_en_o === 1'b1, "frozen state moved");
    @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    foreach (rows[i]) begin
      enter(rows[i].m);
      chk({core_clk_en_o, core_domain_clk_en_o, internal_8mhz_rc_en_o,
        internal_48mhz_rc_en_o, external_high_speed_crystal_en_o, pll_en_o, switchable_core_domain_a_pwr_o,
        switchable_core_domain_b_pwr_o, core_regulator_en_o, sram_upper_retain_o} === rows[i].lp, "low power outputs");
      chk(force_clk_rc8m_o === (rows[i].m != MODE_SLEEP), "clock override");
      pulse(rows[i].s);
      wait_run;
      chk(internal_8mhz_rc_en_o === 1'b1 && (rows[i].m inside {MODE_SLEEP, MODE_STANDBY} ||
        force_clk_rc8m_o === 1'b1), "wake clock");
    end
    chk(wake_count == 7, "wake pulse count");
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk(sys_reset_n_o === 1'b0 && boot_valid_o === 1'b0 && force_clk_rc8m_o === 1'b0, "reset in run");
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    wait_run;
    chk(boot_valid_o === 1'b1 && core_clk_en_o === 1'b1, "run after reset");
    enter(3'h7);
    chk(core_clk_en_o === 1'b1, "bad mode taken");
    enter(MODE_STANDBY);
    pulse(0);
    pulse(1);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(core_regulator_en_o === 1'b0, "standby left on event");
    pulse(7);
    wait_run;
    foreach (bp[i]) begin
      @(posedge sys_clk_i);
      boot_pins_i <= bp[i];
      drive(10 + i % 2, 1'b1);
      @(posedge sys_clk_i);
      #1;
      chk(sys_reset_n_o === 1'b0, "supply low not held");
      @(posedge sys_clk_i);
      drive(10 + i % 2, 1'b0);
      wait_run;
      chk(boot_sel_o === bs[i] && boot_valid_o === 1'b1 && force_clk_rc8m_o === 1'b0, "boot select");
    end
    @(posedge sys_clk_i);
    low_voltage_detector_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(lvd_irq_o === 1'b1, "no warning");
    conclude;
  end
endmodule
